// *** common/ee_slave_regs.vh ***
// Constants for the two-wire serial EEPROM slave
`ifndef EE_SLAVE_REGS_VH
`define EE_SLAVE_REGS_VH

// ------------------------------------------------------------------
// Array geometry
// ------------------------------------------------------------------
`define EE_ADDR_W 15
`define EE_PAGE_W 6
`define EE_PAGE_BYTES 64
`define EE_MEM_BYTES 32768

// ------------------------------------------------------------------
// Device address word fields
// ------------------------------------------------------------------
`define EE_DEV_TYPE_MSB 7
`define EE_DEV_TYPE_LSB 4
`define EE_DEV_CS_MSB 3
`define EE_DEV_CS_LSB 1
`define EE_DEV_RW_BIT 0
// Arbitrary neutral memory-type code
`define EE_DEV_TYPE_CODE 4'h5

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define EE_CLK_NS 40
`define EE_T_WR_NS 5000000
// Five milliseconds of 40 ns clocks, sized to the timer width
`define EE_T_WR_CYC 17'h1_E848
`define EE_TMR_W 17

`endif

// *** core/pin_sync.v ***
// Three-stage synchroniser with agreement filter for outside inputs
`timescale 1ns/100ps
module pin_sync #(
   parameter W = 1,
   parameter [W-1:0] RST = {W{1'b0}}
) (
   input wire i_clk,
   input wire i_rstn,
   input wire [W-1:0] i_pin,
   output reg [W-1:0] o_level
);
   reg [W-1:0] s1_r;
   reg [W-1:0] s2_r;
   reg [W-1:0] s3_r;
   integer k;

   // A bit moves only when the second and third stages agree
   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s1_r <= RST;
         s2_r <= RST;
         s3_r <= RST;
         o_level <= RST;
      end else begin
         s1_r <= i_pin;
         s2_r <= s1_r;
         s3_r <= s2_r;
         for (k = 0; k < W; k = k + 1) begin
            if (s2_r[k] == s3_r[k]) begin
               o_level[k] <= s3_r[k];
            end
         end
      end
   end
endmodule // pin_sync

// *** core/two_wire_eeprom_slave.v ***
// Device-side logic of a two-wire serial EEPROM
// What this block does
// - Sample on clock rise, shift out on fall
// - Data line driven open-drain only
// - Write-protect high blocks all programming
// - 64-byte pages, 14 or 15 address bits
// - Data changes only while clock low
// - Data fall with clock high is START
// - Data rise with clock high is STOP
// - Standby after read STOP or programming end
// - Acknowledge each received byte on ninth clock
// - Standby after power-up, read STOP, programming
// - Top four address bits match type code
// - Chip-select bits must match pins to acknowledge
// - Eighth bit selects read or programming
// - Byte write: two address bytes, data, STOP
// - Ignore bus during internal write cycle
// - Programming cycle finishes within five milliseconds
// - Page write takes up to 63 more bytes
// - Page write increments only low six address bits
// - No address acknowledge while programming runs
// - Locations erased automatically before programming
// - Counter keeps last address plus one
// - Master ack gives next byte, wraps array
`timescale 1ns/100ps
`include "ee_slave_regs.vh"
module two_wire_eeprom_slave #(
   parameter BIG_VARIANT = 1,
   parameter [`EE_TMR_W-1:0] T_WR_CYC = `EE_T_WR_CYC
) (
   input wire i_clk,
   input wire i_rstn,
   input wire i_scl,
   input wire i_sda,
   input wire i_write_protect,
   input wire [2:0] i_chip_select_pins,
   output reg o_sda_o,
   output reg o_sda_oe,
   output reg o_standby
);
   // ---------------------------------------------------------------
   // Local definitions
   // ---------------------------------------------------------------
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_DEV = 3'h1;
   localparam [2:0] ST_AHI = 3'h2;
   localparam [2:0] ST_ALO = 3'h3;
   localparam [2:0] ST_WDAT = 3'h4;
   localparam [2:0] ST_READ = 3'h5;
   localparam AW = `EE_ADDR_W;
   localparam PW = `EE_PAGE_W;
   localparam [AW-1:0] ADDR_MASK = BIG_VARIANT ? {AW{1'b1}} :
      {1'b0, {(AW-1){1'b1}}};

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   wire scl_f;
   wire sda_f;
   wire wp_f;
   wire [2:0] cs_f;

   pin_sync #(.W(2), .RST(2'h3)) u_bus_sync (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_pin({i_scl, i_sda}),
      .o_level({scl_f, sda_f})
   );

   pin_sync #(.W(4), .RST(4'h0)) u_strap_sync (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_pin({i_write_protect, i_chip_select_pins}),
      .o_level({wp_f, cs_f})
   );

   // ---------------------------------------------------------------
   // Bus condition and edge detection
   // ---------------------------------------------------------------
   reg scl_p_r;
   reg sda_p_r;

   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         scl_p_r <= 1'b1;
         sda_p_r <= 1'b1;
      end else begin
         scl_p_r <= scl_f;
         sda_p_r <= sda_f;
      end
   end

   // data edge under high clock is a condition
   wire scl_hi = scl_f & scl_p_r;
   wire start_det = scl_hi & sda_p_r & ~sda_f;
   wire stop_det = scl_hi & ~sda_p_r & sda_f;
   wire scl_rise = scl_f & ~scl_p_r;
   wire scl_fall = ~scl_f & scl_p_r;

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   // 64-byte pages, 15-bit array
   reg [7:0] mem [0:`EE_MEM_BYTES-1];
   reg [7:0] page_mem [0:`EE_PAGE_BYTES-1];
   reg [`EE_PAGE_BYTES-1:0] page_vld_r;

   // ---------------------------------------------------------------
   // Protocol engine
   // ---------------------------------------------------------------
   reg [2:0] state_r;
   reg [3:0] bit_cnt_r;
   reg [7:0] shift_r;
   reg [7:0] tx_r;
   reg [7:0] addr_hi_r;
   reg [AW-1:0] addr_r;
   reg busy_r;
   reg prog_go_r;
   reg [AW-PW-1:0] row_r;
   reg [PW-1:0] prog_idx_r;
   reg prog_copy_r;
   reg [`EE_TMR_W-1:0] tmr_r;

   wire [AW-1:0] addr_inc = addr_r + {{(AW-1){1'b0}}, 1'b1};
   wire [PW-1:0] page_inc = addr_r[PW-1:0] + {{(PW-1){1'b0}}, 1'b1};
   wire [AW-1:0] addr_ld = {addr_hi_r[AW-9:0], shift_r} & ADDR_MASK;
   wire dev_hit =
      (shift_r[`EE_DEV_TYPE_MSB:`EE_DEV_TYPE_LSB] == `EE_DEV_TYPE_CODE)
      && (shift_r[`EE_DEV_CS_MSB:`EE_DEV_CS_LSB] == cs_f);

   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_r <= ST_IDLE;
         bit_cnt_r <= 4'h0;
         shift_r <= 8'h00;
         tx_r <= 8'h00;
         addr_hi_r <= 8'h00;
         addr_r <= {AW{1'b0}};
         o_sda_oe <= 1'b0;
         o_sda_o <= 1'b0;
         page_vld_r <= {`EE_PAGE_BYTES{1'b0}};
         row_r <= {(AW-PW){1'b0}};
         prog_go_r <= 1'b0;
      end else begin
         prog_go_r <= 1'b0;
         if (busy_r) begin
            state_r <= ST_IDLE;
            o_sda_oe <= 1'b0;
         end else if (start_det) begin
            state_r <= ST_DEV;
            bit_cnt_r <= 4'h0;
            o_sda_oe <= 1'b0;
         end else if (stop_det) begin
            if (state_r == ST_WDAT && |page_vld_r && !wp_f) begin
               prog_go_r <= 1'b1;
            end
            // reads fall straight back to standby
            state_r <= ST_IDLE;
            o_sda_oe <= 1'b0;
         end else if (state_r != ST_IDLE && scl_rise) begin
            if (bit_cnt_r < 4'h8) begin
               shift_r <= {shift_r[6:0], sda_f};
            end
            if (bit_cnt_r < 4'h9) begin
               bit_cnt_r <= bit_cnt_r + 4'h1;
            end
            if (state_r == ST_READ && bit_cnt_r == 4'h8 && sda_f) begin
               state_r <= ST_IDLE;
            end
         end else if (state_r != ST_IDLE && scl_fall) begin
            if (bit_cnt_r == 4'h8) begin
               o_sda_oe <= 1'b0;
               case (state_r)
                  ST_DEV: begin
                     if (dev_hit) begin
                        o_sda_oe <= 1'b1;
                        if (shift_r[`EE_DEV_RW_BIT]) begin
                           state_r <= ST_READ;
                        end else begin
                           state_r <= ST_AHI;
                        end
                     end else begin
                        state_r <= ST_IDLE;
                     end
                  end
                  ST_AHI: begin
                     addr_hi_r <= shift_r;
                     o_sda_oe <= 1'b1;
                     state_r <= ST_ALO;
                  end
                  ST_ALO: begin
                     // small part drops the top bit
                     addr_r <= addr_ld;
                     row_r <= addr_ld[AW-1:PW];
                     page_vld_r <= {`EE_PAGE_BYTES{1'b0}};
                     o_sda_oe <= 1'b1;
                     state_r <= ST_WDAT;
                  end
                  ST_WDAT: begin
                     page_vld_r[addr_r[PW-1:0]] <= 1'b1;
                     addr_r <= {addr_r[AW-1:PW], page_inc};
                     o_sda_oe <= 1'b1;
                  end
                  ST_READ: begin
                     // Release for the master acknowledge
                     o_sda_oe <= 1'b0;
                  end
                  default: begin
                     state_r <= ST_IDLE;
                  end
               endcase
            end else if (bit_cnt_r == 4'h9) begin
               bit_cnt_r <= 4'h0;
               o_sda_oe <= 1'b0;
               if (state_r == ST_READ) begin
                  // read at counter then bump it
                  tx_r <= {mem[addr_r][6:0], 1'b0};
                  o_sda_oe <= ~mem[addr_r][7];
                  addr_r <= addr_inc & ADDR_MASK;
               end
            end else if (state_r == ST_READ) begin
               o_sda_oe <= ~tx_r[7];
               tx_r <= {tx_r[6:0], 1'b0};
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Page buffer capture
   // ---------------------------------------------------------------
   always @(posedge i_clk) begin
      if (!busy_r && state_r == ST_WDAT && scl_fall && bit_cnt_r == 4'h8
          && !start_det && !stop_det) begin
         page_mem[addr_r[PW-1:0]] <= shift_r;
      end
   end

   // ---------------------------------------------------------------
   // Self-timed programming
   // ---------------------------------------------------------------
   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         busy_r <= 1'b0;
         prog_idx_r <= {PW{1'b0}};
         prog_copy_r <= 1'b0;
         tmr_r <= {`EE_TMR_W{1'b0}};
      end else if (prog_go_r) begin
         busy_r <= 1'b1;
         prog_copy_r <= 1'b1;
         prog_idx_r <= {PW{1'b0}};
         tmr_r <= T_WR_CYC;
      end else if (busy_r) begin
         if (prog_copy_r) begin
            prog_idx_r <= prog_idx_r + {{(PW-1){1'b0}}, 1'b1};
            if (&prog_idx_r) begin
               prog_copy_r <= 1'b0;
            end
         end
         // cycle closes at the five millisecond count
         if (tmr_r <= {{(`EE_TMR_W-1){1'b0}}, 1'b1}) begin
            busy_r <= 1'b0;
         end else begin
            tmr_r <= tmr_r - {{(`EE_TMR_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // Whole-byte overwrite stands in for erase-then-program
   always @(posedge i_clk) begin
      if (busy_r && prog_copy_r && page_vld_r[prog_idx_r]) begin
         mem[{row_r, prog_idx_r}] <= page_mem[prog_idx_r];
      end
   end

   // ---------------------------------------------------------------
   // Standby indication
   // ---------------------------------------------------------------
   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_standby <= 1'b1;
      end else begin
         // standby when idle and not programming
         // busy part never acks, so polling sees nack
         o_standby <= (state_r == ST_IDLE) && !busy_r && !prog_go_r;
      end
   end
endmodule // two_wire_eeprom_slave

// *** verif/ee_slave_chk_sva.sv ***
// Port checker for the two-wire EEPROM slave
`timescale 1ns/100ps
`include "ee_slave_regs.vh"
module ee_slave_chk #(
   parameter BIG_VARIANT = 1,
   parameter [`EE_TMR_W-1:0] T_WR_CYC = `EE_T_WR_CYC
) (
   input wire i_clk,
   input wire i_rstn,
   input wire i_scl,
   input wire i_sda,
   input wire i_write_protect,
   input wire [2:0] i_chip_select_pins,
   input wire o_sda_o,
   input wire o_sda_oe,
   input wire o_standby
);
   reg prog_r;
   reg stby_p_r;
   reg [17:0] cnt_r;
   // Programming starts when standby drops on an idle bus
   wire prog_start = stby_p_r & ~o_standby & i_scl & i_sda;
   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         prog_r <= 1'h0;
         stby_p_r <= 1'h1;
         cnt_r <= 18'h0_0000;
      end else begin
         prog_r <= (prog_r | prog_start) & ~o_standby;
         stby_p_r <= o_standby;
         cnt_r <= prog_r ? cnt_r + 18'h0_0001 : 18'h0_0000;
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   a_open_drain: assert property (o_sda_o == 1'h0)
      else $error("data output not held low");
   // The clock pin fell five edges before the change is seen here
   a_pull_on_low: assert property ($rose(o_sda_oe) |-> !$past(i_scl))
      else $error("pull began with clock high");
   a_release_low: assert property ($fell(o_sda_oe) |-> !$past(i_scl))
      else $error("release with clock high");
   a_ack_stands: assert property ($rose(o_sda_oe) |-> o_sda_oe[*4])
      else $error("pull too short");
   a_prog_quiet: assert property (prog_r |-> !o_sda_oe)
      else $error("bus answered while programming");
   a_prog_bound: assert property (prog_r |-> cnt_r <= T_WR_CYC + 4)
      else $error("programming ran too long");
   a_wp_blocks: assert property ($fell(o_standby) && i_scl && i_sda
      |-> !i_write_protect) else $error("programming despite protect");
   a_reset_idle: assert property ($rose(i_rstn)
      |-> !o_sda_oe && o_standby) else $error("not idle after reset");
endmodule // ee_slave_chk
bind two_wire_eeprom_slave ee_slave_chk #(.BIG_VARIANT(BIG_VARIANT),
   .T_WR_CYC(T_WR_CYC)) ee_slave_chk_i (.i_clk(i_clk), .i_rstn(i_rstn),
   .i_scl(i_scl), .i_sda(i_sda), .i_write_protect(i_write_protect),
   .i_chip_select_pins(i_chip_select_pins), .o_sda_o(o_sda_o),
   .o_sda_oe(o_sda_oe), .o_standby(o_standby));

// *** verif/bus_master.sv ***
// Two-wire bus master model paced by the system clock
`timescale 1ns/100ps
module bus_master (
   input wire i_clk,
   input wire i_sda,
   output reg o_scl = 1'h1,
   output reg o_sda_m = 1'h1
);
   reg seen_r;
   // lines move after n falling edges
   task ph(input integer n, input c, input s);
      begin
         repeat (n) @(negedge i_clk);
         o_scl = c;
         o_sda_m = s;
      end
   endtask
   // Low 5 clocks so the device answer lands before the rise
   task send_bit(input b);
      begin
         ph(1, 1'h0, b);
         ph(4, 1'h1, b);
         ph(2, 1'h1, b);
         seen_r = i_sda;
         ph(1, 1'h0, b);
      end
   endtask
   task start;
      begin
         ph(1, o_scl, 1'h1);
         ph(4, 1'h1, 1'h1);
         ph(2, 1'h1, 1'h0);
         ph(2, 1'h0, 1'h0);
      end
   endtask
   // closing rise, clock then stands still
   task stop;
      begin
         ph(1, 1'h0, 1'h0);
         ph(4, 1'h1, 1'h0);
         ph(4, 1'h1, 1'h1);
      end
   endtask
   task wr_byte(input [7:0] d, output ack);
      integer i;
      begin
         for (i = 7; i >= 0; i = i - 1) begin
            send_bit(d[i]);
         end
         send_bit(1'h1);
         ack = ~seen_r;
      end
   endtask
   // ack to go on, nack on the last
   task rd_byte(input last, output [7:0] d);
      integer i;
      begin
         for (i = 0; i < 8; i = i + 1) begin
            send_bit(1'h1);
            d[7 - i] = seen_r;
         end
         send_bit(last);
      end
   endtask
endmodule // bus_master

// *** verif/two_wire_eeprom_slave_tb.sv ***
// Self-checking bench for the two-wire EEPROM slave
`timescale 1ns/100ps
`include "ee_slave_regs.vh"
module two_wire_eeprom_slave_tb;
   localparam [2:0] CS = 3'h5;
   reg i_clk = 1'h0;
   reg i_rstn = 1'h0;
   reg i_write_protect = 1'h0;
   reg [2:0] cs_pins = CS;
   wire scl;
   wire sda_m;
   wire sda_oe;
   wire standby;
   // Pull-up resolves the shared data line
   wire sda = sda_m & ~sda_oe;
   integer errors = 0;
   integer checked = 0;
   reg ack;
   reg [15:0] v;
   always #20 i_clk = ~i_clk;
   two_wire_eeprom_slave #(.BIG_VARIANT(1'h1), .T_WR_CYC(17'h0_00C8))
      two_wire_eeprom_slave_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_scl(scl),
      .i_sda(sda), .i_write_protect(i_write_protect),
      .i_chip_select_pins(cs_pins), .o_sda_o(), .o_sda_oe(sda_oe),
      .o_standby(standby));
   bus_master bus_master_i (.i_clk(i_clk), .i_sda(sda), .o_scl(scl),
      .o_sda_m(sda_m));
   task check(input string name, input [15:0] seen, input [15:0] exp);
      begin
         checked = checked + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
         end
      end
   endtask
   function [7:0] dev(input rw);
      dev = {`EE_DEV_TYPE_CODE, CS, rw};
   endfunction
   task tx(input [31:0] d, input integer n);
      integer i;
      begin
         for (i = 0; i < n; i = i + 1) begin
            bus_master_i.wr_byte(d[31 - 8 * i -: 8], ack);
            check("ack", ack, 1'h1);
         end
      end
   endtask
   task point(input [14:0] a);
      begin
         bus_master_i.start;
         tx({dev(1'h0), 1'h0, a, 8'h00}, 3);
      end
   endtask
   task write(input [14:0] a, input [31:0] d, input integer n, input poll);
      integer k;
      begin
         point(a);
         tx(d, n);
         bus_master_i.stop;
         repeat (8) @(negedge i_clk);
         if (poll) begin
            check("busy", standby, 1'h0);
            bus_master_i.start;
            bus_master_i.wr_byte(dev(1'h1), ack);
            check("poll nack", ack, 1'h0);
            bus_master_i.stop;
         end
         k = 0;
         while (standby !== 1'h1 && k < 400) begin
            @(negedge i_clk);
            k = k + 1;
         end
         check("standby", standby, 1'h1);
      end
   endtask
   task rd_seq(input [14:0] a);
      begin
         point(a);
         bus_master_i.start;
         tx({dev(1'h1), 24'h00_0000}, 1);
         bus_master_i.rd_byte(1'h0, v[15:8]);
         bus_master_i.rd_byte(1'h1, v[7:0]);
         bus_master_i.stop;
      end
   endtask
   task t_no_match;
      integer i;
      begin
         for (i = 0; i < 4; i = i + 1) begin
            bus_master_i.start;
            bus_master_i.wr_byte(dev(1'h0) ^ (8'h02 << i), ack);
            check("foreign nack", ack, 1'h0);
            bus_master_i.stop;
         end
         // Pins moved: old code refused, new code taken
         cs_pins = 3'h2;
         bus_master_i.start;
         bus_master_i.wr_byte(dev(1'h0), ack);
         check("old pins", ack, 1'h0);
         bus_master_i.stop;
         bus_master_i.start;
         bus_master_i.wr_byte({`EE_DEV_TYPE_CODE, 3'h2, 1'h0}, ack);
         check("new pins", ack, 1'h1);
         bus_master_i.stop;
         cs_pins = CS;
      end
   endtask
   task t_write_poll;
      begin
         write(15'h0123, 32'hA500_0000, 1, 1'h1);
         rd_seq(15'h0123);
         check("byte", v[15:8], 8'hA5);
      end
   endtask
   task t_page;
      begin
         write(15'h0000, 32'hC300_0000, 1, 1'h0);
         write(15'h7FFF, 32'h1122_3344, 4, 1'h0);
         rd_seq(15'h7FFF);
         check("array wrap", v, 16'h11C3);
         rd_seq(15'h7FC0);
         check("page wrap", v, 16'h2233);
         bus_master_i.start;
         tx({dev(1'h1), 24'h00_0000}, 1);
         bus_master_i.rd_byte(1'h1, v[7:0]);
         bus_master_i.stop;
         check("current", v[7:0], 8'h44);
      end
   endtask
   task t_wp;
      begin
         i_write_protect = 1'h1;
         write(15'h0123, 32'h3C00_0000, 1, 1'h0);
         rd_seq(15'h0123);
         check("protected", v[15:8], 8'hA5);
         i_write_protect = 1'h0;
         write(15'h0123, 32'h3C00_0000, 1, 1'h0);
         rd_seq(15'h0123);
         check("rewritten", v[15:8], 8'h3C);
      end
   endtask
   task tally_and_finish;
      begin
         $display("checked %0d errors %0d", checked, errors);
         if (errors == 0 && checked > 0) begin
            $display("*** PASS ***");
         end else begin
            $display("*** FAIL ***");
         end
         $finish;
      end
   endtask
   initial begin
      repeat (2) @(posedge i_clk);
      @(negedge i_clk);
      i_rstn = 1'h1;
      repeat (6) @(negedge i_clk);
      t_no_match;
      t_write_poll;
      t_page;
      t_wp;
      tally_and_finish;
   end
   // Runs need some 5600 clocks; this cuts a hang well beyond that
   initial begin
      #2000000;
      errors = errors + 1;
      tally_and_finish;
   end
endmodule // two_wire_eeprom_slave_tb
